// ---- hw/bbw_pkg.sv ----
// package: constants for the branch, bit and wait control block
package bbw_pkg;
    localparam int unsigned CLK_HZ          = 25000000;
    localparam int unsigned WDOG_CYCLES     = 114688;
    localparam logic [7:0]  OP_BTEST_BASE   = 8'h00;
    localparam logic [7:0]  OP_BMOD_BASE    = 8'h10;
    localparam logic [3:0]  OP_REL_HI       = 4'h2;
    localparam logic [7:0]  OP_HALT         = 8'h8e;
    localparam logic [7:0]  OP_WAIT         = 8'h8f;
    localparam logic [15:0] REL_NEXT        = 16'h0002;
    localparam logic [15:0] BTB_NEXT        = 16'h0003;
    localparam logic [15:0] ONE_NEXT        = 16'h0001;
    localparam logic [15:0] RESET_ADDR      = 16'h0000;
    localparam logic [7:0]  ZERO_PAGE_HI    = 8'h00;
    localparam logic [15:0] WDOG_LAST       = 16'hffff;

    typedef enum logic [3:0] {
        ST_FETCH   = 4'b0000,
        ST_OPER1   = 4'b0001,
        ST_OPER2   = 4'b0010,
        ST_READ    = 4'b0011,
        ST_WRITE   = 4'b0100,
        ST_WAIT    = 4'b0101,
        ST_STACK   = 4'b0110,
        ST_DECIDE  = 4'b0111,
        ST_VECTOR  = 4'b1000
    } state_t;
endpackage

// ---- hw/cpu_branch_bit_wait_control.sv ----
// branch, bit set/clear, bit test and wait control of the cpu core
// Functional notes
// - branch adds signed offset only when taken
// - relative target from opcode plus two
// - bit number from opcode, zero-page operand address
// - modify one bit, keep others unchanged
// - bit test: sense from opcode, address, offset
// - bit test target from opcode plus three
// - tested bit copied into carry flag
// - halt executes as no-operation, mask untouched
// - wait gates processor clock, peripherals run
// - wait clears interrupt mask bit
// - wait holds registers, memory and lines
// - watchdog always on, resets on timeout
`timescale 1ns/1ps
`default_nettype none
module cpu_branch_bit_wait_control
    import bbw_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // internal memory bus
    output logic [15:0]      bus_addr,
    output logic             bus_rd,
    output logic             bus_wr,
    output logic [7:0]       bus_wdata,
    input  wire logic [7:0]  bus_rdata,
    // branch condition from the rest of the core
    input  wire logic        branch_cond,
    // interrupts and watchdog
    input  wire logic        irq_req,
    input  wire logic        wdog_service,
    output logic             irq_ack,
    output logic             wdog_reset,
    // status
    output logic [15:0]      program_counter,
    output logic             carry_flag,
    output logic             int_mask,
    output logic             cpu_clk_en
);
    state_t      state;
    state_t      next_state;
    logic [7:0]  opcode;
    logic [7:0]  next_opcode;
    logic [7:0]  test_operand_address;
    logic [7:0]  next_test_operand_address;
    logic [7:0]  data;
    logic [7:0]  next_data;
    logic [15:0] next_program_counter;
    logic        next_carry_flag;
    logic        next_int_mask;
    logic        wd_timeout;
    logic [15:0] branch_target_address;

    // ------------------------------------------------------------
    // opcode classification
    // ------------------------------------------------------------
    function automatic logic is_btb(input logic [7:0] op);
        is_btb = (op[7:4] == OP_BTEST_BASE[7:4]);
    endfunction

    function automatic logic is_bmod(input logic [7:0] op);
        is_bmod = (op[7:4] == OP_BMOD_BASE[7:4]);
    endfunction

    function automatic logic [2:0] bit_num(input logic [7:0] op);
        bit_num = op[3:1];
    endfunction

    // even opcode sets, or branches on set
    function automatic logic bit_sense(input logic [7:0] op);
        bit_sense = ~op[0];
    endfunction

    function automatic logic is_rel(input logic [7:0] op);
        is_rel = (op[7:4] == OP_REL_HI);
    endfunction

    function automatic logic [15:0] sext(input logic [7:0] off);
        sext = {{8{off[7]}}, off};
    endfunction

    // ------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------
    operating_watchdog u_wdog (
        .clk     (clk),
        .rst_n   (rst_n),
        .service (wdog_service),
        .timeout (wd_timeout)
    );
    assign wdog_reset = wd_timeout;

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_state                = state;
        next_opcode               = opcode;
        next_test_operand_address = test_operand_address;
        next_data                 = data;
        next_program_counter      = program_counter;
        next_carry_flag           = carry_flag;
        next_int_mask             = int_mask;
        branch_target_address     = program_counter;
        bus_addr                  = program_counter;
        bus_rd                    = 1'b0;
        bus_wr                    = 1'b0;
        bus_wdata                 = data;
        irq_ack                   = 1'b0;
        case (state)
            ST_FETCH: begin
                bus_rd      = 1'b1;
                next_opcode = bus_rdata;
                if (bus_rdata == OP_WAIT) begin
                    next_int_mask        = 1'b0;
                    next_program_counter = program_counter + ONE_NEXT;
                    next_state           = ST_WAIT;
                end else if (bus_rdata == OP_HALT) begin
                    next_program_counter = program_counter + ONE_NEXT;
                end else if (is_btb(bus_rdata) || is_bmod(bus_rdata) || is_rel(bus_rdata)) begin
                    next_state = ST_OPER1;
                end else begin
                    next_program_counter = program_counter + ONE_NEXT;
                end
            end
            ST_OPER1: begin
                bus_addr = program_counter + ONE_NEXT;
                bus_rd   = 1'b1;
                if (is_rel(opcode)) begin
                    branch_target_address = program_counter + REL_NEXT + sext(bus_rdata);
                    next_program_counter  = branch_cond ? branch_target_address
                                                        : program_counter + REL_NEXT;
                    next_state = ST_FETCH;
                end else begin
                    next_test_operand_address = bus_rdata;
                    next_state                = ST_READ;
                end
            end
            ST_READ: begin
                bus_addr  = {ZERO_PAGE_HI, test_operand_address};
                bus_rd    = 1'b1;
                next_data = bus_rdata;
                next_state = is_btb(opcode) ? ST_OPER2 : ST_WRITE;
            end
            ST_WRITE: begin
                bus_addr = {ZERO_PAGE_HI, test_operand_address};
                bus_wr   = 1'b1;
                bus_wdata = data;
                bus_wdata[bit_num(opcode)] = bit_sense(opcode);
                next_program_counter = program_counter + REL_NEXT;
                next_state = ST_FETCH;
            end
            ST_OPER2: begin
                bus_addr = program_counter + REL_NEXT;
                bus_rd   = 1'b1;
                next_carry_flag = data[bit_num(opcode)];
                branch_target_address = program_counter + BTB_NEXT + sext(bus_rdata);
                // even opcode branches on set, odd on clear
                if (data[bit_num(opcode)] == bit_sense(opcode)) begin
                    next_program_counter = branch_target_address;
                end else begin
                    next_program_counter = program_counter + BTB_NEXT;
                end
                next_state = ST_FETCH;
            end
            ST_WAIT: begin
                // nothing moves while the clock is gated
                if (irq_req && !int_mask) begin
                    next_state = ST_STACK;
                end
            end
            ST_STACK: begin
                irq_ack       = 1'b1;
                next_int_mask = 1'b1;
                next_state    = ST_VECTOR;
            end
            ST_VECTOR: begin
                next_state = ST_FETCH;
            end
            default: begin
                next_state = ST_FETCH;
            end
        endcase
        // watchdog timeout restarts the core
        if (wd_timeout) begin
            next_state                = ST_FETCH;
            next_opcode               = 8'h00;
            next_test_operand_address = 8'h00;
            next_data                 = 8'h00;
            next_program_counter      = RESET_ADDR;
            next_carry_flag           = 1'b0;
            next_int_mask             = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // processor clock gate
    // ------------------------------------------------------------
    assign cpu_clk_en = (state != ST_WAIT);

    // ------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state                <= ST_FETCH;
            opcode               <= 8'h00;
            test_operand_address <= 8'h00;
            data                 <= 8'h00;
            program_counter      <= RESET_ADDR;
            carry_flag           <= 1'b0;
            int_mask             <= 1'b1;
        end else begin
            state                <= next_state;
            opcode               <= next_opcode;
            test_operand_address <= next_test_operand_address;
            data                 <= next_data;
            program_counter      <= next_program_counter;
            carry_flag           <= next_carry_flag;
            int_mask             <= next_int_mask;
        end
    end
endmodule
`default_nettype wire

// ---- hw/operating_watchdog.sv ----
// watchdog counter that runs on the free clock
`timescale 1ns/1ps
`default_nettype none
module operating_watchdog
    import bbw_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // service and timeout
    input  wire logic service,
    output logic      timeout
);
    logic [16:0] count;
    logic [16:0] next_count;

    // ------------------------------------------------------------
    // always counting, also in wait
    // ------------------------------------------------------------
    always_comb begin
        if (service || count == 17'(WDOG_CYCLES - 1)) begin
            next_count = 17'h00000;
        end else begin
            next_count = count + 17'h00001;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= 17'h00000;
        end else begin
            count <= next_count;
        end
    end

    assign timeout = !service && (count == 17'(WDOG_CYCLES - 1));
endmodule
`default_nettype wire

// ---- tb/bbw_chk_chk.sv ----
// assertions on the branch, bit and wait control ports
`timescale 1ns/1ps
`default_nettype none
module bbw_chk (
    // watched ports
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic [15:0] bus_addr,
    input wire logic        bus_rd,
    input wire logic        bus_wr,
    input wire logic [7:0]  bus_wdata,
    input wire logic [7:0]  bus_rdata,
    input wire logic        irq_req,
    input wire logic        irq_ack,
    input wire logic [15:0] program_counter,
    input wire logic        carry_flag,
    input wire logic        int_mask,
    input wire logic        cpu_clk_en
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_WAIT_QUIET: assert property (!cpu_clk_en |-> !bus_rd && !bus_wr) else $error("bus busy in wait");
    AST_WAIT_MASK: assert property (!cpu_clk_en |-> !int_mask) else $error("mask set in wait");
    AST_WAIT_HOLD: assert property (!cpu_clk_en ##1 !cpu_clk_en |-> $stable(program_counter))
        else $error("counter moved in wait");
    AST_WAIT_CARRY: assert property (!cpu_clk_en ##1 !cpu_clk_en |-> $stable(carry_flag))
        else $error("carry moved in wait");
    AST_MASK_FALL: assert property ($fell(int_mask) |-> $past(bus_rdata) == bbw_pkg::OP_WAIT)
        else $error("mask cleared off wait");
    AST_WAKE: assert property (!cpu_clk_en && irq_req |-> ##[1:2] irq_ack) else $error("no wake");
    AST_ACK_CAUSE: assert property (irq_ack |-> !$past(cpu_clk_en) && $past(irq_req))
        else $error("stray ack");
    AST_ACK_MASK: assert property (irq_ack |=> int_mask && cpu_clk_en) else $error("mask not set");
    AST_ZP_WRITE: assert property (bus_wr |-> bus_addr[15:8] == 8'h00) else $error("write off zero page");
    AST_ONE_BIT: assert property (bus_wr |-> $countones(bus_wdata ^ $past(bus_rdata)) <= 1)
        else $error("write not one bit");
endmodule
bind cpu_branch_bit_wait_control bbw_chk i_bbw_chk (.clk, .rst_n, .bus_addr, .bus_rd, .bus_wr, .bus_wdata,
    .bus_rdata, .irq_req, .irq_ack, .program_counter, .carry_flag, .int_mask, .cpu_clk_en);
`default_nettype wire

// ---- tb/cpu_branch_bit_wait_control_bench.sv ----
// bench for the branch, bit and wait control block
`timescale 1ns/1ps
`default_nettype none
module cpu_branch_bit_wait_control_bench;
    import bbw_pkg::*;
    logic        clk = 1'b0, rst_n = 1'b0, branch_cond = 1'b0, irq_req = 1'b0, wdog_service = 1'b0;
    logic        bus_rd, bus_wr, irq_ack, carry_flag, int_mask, cpu_clk_en, wdog_reset;
    logic [15:0] bus_addr, program_counter;
    logic [7:0]  bus_wdata, bus_rdata;
    int          errors = 0, compares = 0, cycles = 0;
    cpu_branch_bit_wait_control i_cpu_branch_bit_wait_control (.clk, .rst_n, .bus_addr, .bus_rd, .bus_wr,
        .bus_wdata, .bus_rdata, .branch_cond, .irq_req, .wdog_service, .irq_ack, .wdog_reset,
        .program_counter, .carry_flag, .int_mask, .cpu_clk_en);
    mem_model i_mem_model (.clk, .bus_addr, .bus_rd, .bus_wr, .bus_wdata, .bus_rdata);
    initial forever #20 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        wdog_service <= (cycles % 16 == 0);
        if (cycles == 4000) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, cycles, 4000);
            give_verdict();
        end
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) errors++;
        if (got !== exp) $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    endtask
    task automatic give_verdict();
        if (errors == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic fill(input logic cond);
        @(posedge clk);
        rst_n       <= 1'b0;
        branch_cond <= cond;
        for (int a = 0; a < 256; a++) i_mem_model.mem[a] = OP_WAIT;
        i_mem_model.mem[8'h40] = 8'h1b;
    endtask
    task automatic put(input logic [7:0] a, input logic [7:0] b0, input logic [7:0] b1);
        i_mem_model.mem[a]         = b0;
        i_mem_model.mem[a + 8'h01] = b1;
    endtask
    // release reset, run to the wait, check, then wake
    task automatic stop_at(input logic [15:0] exp_addr, input logic exp_c);
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        for (int n = 0; n < 200 && cpu_clk_en !== 1'b0; n++) #40;
        check({15'h0, int_mask}, 16'h0000);
        check({15'h0, carry_flag}, {15'h0, exp_c});
        check(program_counter, exp_addr);
        check({15'h0, wdog_reset}, 16'h0000);
        @(posedge clk);
        irq_req <= 1'b1;
        #1;
        for (int n = 0; n < 10 && irq_ack !== 1'b1; n++) #40;
        check({15'h0, irq_ack}, 16'h0001);
        @(posedge clk);
        irq_req <= 1'b0;
    endtask
    task automatic test_rel(input logic cond, input logic [15:0] exp_addr);
        fill(cond);
        put(8'h00, 8'h20, 8'h7f);
        put(8'h81, 8'h20, 8'h80);
        stop_at(exp_addr, 1'b0);
    endtask
    task automatic test_bits();
        fill(1'b0);
        put(8'h00, OP_HALT, 8'h14);
        put(8'h02, 8'h40, 8'h19);
        put(8'h04, 8'h40, OP_WAIT);
        stop_at(16'h0006, 1'b0);
        check({8'h00, i_mem_model.mem[8'h40]}, 16'h000f);
    endtask
    task automatic test_bt(input logic [7:0] op, input logic [15:0] exp_addr, input logic exp_c);
        fill(1'b0);
        put(8'h00, op, 8'h40);
        put(8'h02, 8'h7f, OP_WAIT);
        stop_at(exp_addr, exp_c);
    endtask
    initial begin
        test_rel(1'b1, 16'h0004);
        test_rel(1'b0, 16'h0003);
        test_bits();
        test_bt(8'h02, 16'h0083, 1'b1);
        test_bt(8'h03, 16'h0004, 1'b1);
        test_bt(8'h04, 16'h0004, 1'b0);
        test_bt(8'h05, 16'h0083, 1'b0);
        give_verdict();
    end
endmodule
`default_nettype wire

// ---- tb/mem_model.sv ----
// zero-wait memory on the far side of the cpu bus
`timescale 1ns/1ps
`default_nettype none
module mem_model (
    // bus
    input  wire logic        clk,
    input  wire logic [15:0] bus_addr,
    input  wire logic        bus_rd,
    input  wire logic        bus_wr,
    input  wire logic [7:0]  bus_wdata,
    output logic [7:0]       bus_rdata
);
    logic [7:0] mem [0:255];
    logic [7:0] last = 8'h00;
    // released bus shows inverse of last byte
    assign bus_rdata = bus_rd ? mem[bus_addr[7:0]] : ~last;
    always @(posedge clk) begin
        if (bus_rd) last <= mem[bus_addr[7:0]];
        if (bus_wr) mem[bus_addr[7:0]] <= bus_wdata;
    end
endmodule
`default_nettype wire
